// >>> swv_wakeup_voltage.v
// Purpose: Identification, periodic wakeup timer and supply-drop control
// Assumes: APB slave, zero wait states, synchronous active-low reset
// Notes: Analogue comparator and stop entry are outside; their results
//        arrive as inputs. Registers are bytes in the low lanes.
// What this block does
// - High ID register upper nibble returns fixed revision; writes ignored.
// - Part number spans ID high low nibble and ID low byte.
// - Wakeup flag bit 7 sets when the timer period expires.
// - Writing 1 to wakeup acknowledge bit 6 clears flag; reads 0.
// - Clock select bit 5 picks internal tick or external clock.
// - Wakeup interrupt enable bit 4 gates wakeup requests.
// - Period select zero keeps the wakeup timer disabled.
// - Internal tick periods 8 to 512 ms and 1.024 s.
// - External clock periods 256 to 32768 external clock periods.
// - Unimplemented wakeup control bits read zero, ignore writes.
// - Supply-drop flag bit 7 sets on detect events while enabled.
// - Writing 1 to supply-drop acknowledge bit 6 clears flag; reads 0.
// - Supply-drop interrupt enable bit 5 requests interrupt while flag set.
// - Reset enable bit 4 with detect enabled forces device reset while flag set.
// - Stop enable bit 3 keeps detection running in stop mode.
// - Detect enable bit 2 qualifies flag, interrupt, reset, stop.
// - Write-once bits accept only the first write after reset.
// - Detection stops in stop mode unless stop enable set.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "swv_regs.vh"
module swv_wakeup_voltage #(
    parameter [3:0] REVISION = 4'h1,     // Arbitrary value
    parameter [11:0] PART_NUMBER = 12'h5a3, // Arbitrary value
    parameter TICK_CYCLES = `SWV_TICK_NS / `SWV_CLK_NS
) (
    input wire clk_sys,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire extClk,
    input wire supplyDropEvent,
    input wire stopMode,
    output reg wakeupIrq,
    output reg supplyDropIrq,
    output reg supplyDropReset,
    output reg detectActive
);
    // Bits needed to hold a count, so the tick counter fits its parameter
    function integer swvBits(input integer value);
        integer rest;
        begin
            swvBits = 1;
            rest = value >> 1;
            while (rest != 0) begin
                swvBits = swvBits + 1;
                rest = rest >> 1;
            end
        end
    endfunction
    localparam TICK_W = swvBits(TICK_CYCLES);
    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

    reg wakeupFlag;
    reg wakeupClockSelect;
    reg wakeupInterruptEnable;
    reg [2:0] wakeupPeriodSelect;
    reg supplyDropFlag;
    reg supplyDropInterruptEnable;
    reg supplyDropResetEnable;
    reg supplyDropStopEnable;
    reg supplyDropDetectEnable;
    reg dropWritten;
    reg [TICK_W-1:0] tickCount;
    reg [14:0] periodCount;
    reg extSync0;
    reg extSync1;
    reg extLast;
    reg [14:0] periodLimit;
    reg [7:0] rdByte;
    wire [15:0] regIdx;
    wire access;
    wire wrLow;
    wire hitIdH;
    wire hitIdL;
    wire hitWake;
    wire hitDrop;
    wire mapped;
    wire tickPulse;
    wire extPulse;
    wire timerStep;
    wire wakeExpire;
    wire dropWr;
    wire wakeWr;
    wire wakeCfgChange;
    wire wdAck;
    wire wdClockSelect;
    wire wdWakeIe;
    wire [2:0] wdPeriod;
    wire wdDropIe;
    wire wdResetEnable;
    wire wdStopEnable;
    wire wdDetectEnable;
    wire wakeAck;
    wire dropAck;
    wire detectOn;

    assign regIdx = paddr[`SWV_ADDR_W-1:2];
    assign access = psel & penable;
    assign hitIdH = regIdx == `SWV_IDX_ID_HIGH;
    assign hitIdL = regIdx == `SWV_IDX_ID_LOW;
    assign hitWake = regIdx == `SWV_IDX_WAKE_CTRL;
    assign hitDrop = regIdx == `SWV_IDX_DROP_CTRL;
    assign mapped = (paddr[31:`SWV_ADDR_W] == 14'h0000) &
        (paddr[1:0] == 2'h0) & (hitIdH | hitIdL | hitWake | hitDrop);
    // Only byte lane 0 holds register bits
    assign wrLow = access & pwrite & mapped & pstrb[0];
    assign wakeWr = wrLow & hitWake;
    assign dropWr = wrLow & hitDrop;
    // Write data split into the named fields
    assign wdAck = pwdata[`SWV_BIT_ACK];
    assign wdClockSelect = pwdata[`SWV_BIT_CLKSEL];
    assign wdWakeIe = pwdata[`SWV_BIT_WIE];
    assign wdPeriod = pwdata[`SWV_PER_MSB:`SWV_PER_LSB];
    assign wdDropIe = pwdata[`SWV_BIT_DIE];
    assign wdResetEnable = pwdata[`SWV_BIT_DRE];
    assign wdStopEnable = pwdata[`SWV_BIT_DSE];
    assign wdDetectEnable = pwdata[`SWV_BIT_DDE];
    assign wakeAck = wakeWr & wdAck;
    assign dropAck = dropWr & wdAck;

    // APB: zero wait, error on unmapped address
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= (psel & ~penable & ~pwrite & mapped) ?
                {24'h000000, rdByte} : 32'h00000000;
        end
    end

    // Setup phase decode so prdata holds the read byte on the access cycle
    always @* begin
        rdByte = 8'h00;
        if (hitIdH) begin
            rdByte = {REVISION, PART_NUMBER[11:8]};
        end else if (hitIdL) begin
            rdByte = PART_NUMBER[7:0];
        end else if (hitWake) begin
            // bit 3 and acknowledge read zero
            rdByte[`SWV_BIT_FLAG] = wakeupFlag;
            rdByte[`SWV_BIT_CLKSEL] = wakeupClockSelect;
            rdByte[`SWV_BIT_WIE] = wakeupInterruptEnable;
            rdByte[`SWV_PER_MSB:`SWV_PER_LSB] = wakeupPeriodSelect;
        end else if (hitDrop) begin
            // Acknowledge and low two bits stay zero
            rdByte[`SWV_BIT_FLAG] = supplyDropFlag;
            rdByte[`SWV_BIT_DIE] = supplyDropInterruptEnable;
            rdByte[`SWV_BIT_DRE] = supplyDropResetEnable;
            rdByte[`SWV_BIT_DSE] = supplyDropStopEnable;
            rdByte[`SWV_BIT_DDE] = supplyDropDetectEnable;
        end
    end

    // Extended APB timing: slave answers on the access cycle
    // (pready computed from setup above is registered into access)

    // Internal 1 ms tick from bus clock
    assign tickPulse = tickCount == TICK_LAST[TICK_W-1:0];
    always @(posedge clk_sys) begin
        if (!rst_n || tickPulse) begin
            tickCount <= {TICK_W{1'b0}};
        end else begin
            tickCount <= tickCount + {{(TICK_W-1){1'b0}}, 1'b1};
        end
    end

    // External clock treated as asynchronous, edge-detected after two flops
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            extSync0 <= 1'b0;
            extSync1 <= 1'b0;
            extLast <= 1'b0;
        end else begin
            extSync0 <= extClk;
            extSync1 <= extSync0;
            extLast <= extSync1;
        end
    end
    assign extPulse = extSync1 & ~extLast;

    assign timerStep = wakeupClockSelect ? extPulse : tickPulse;

    // external periods in clock edges
    // Limits are one below the step count, the expiring step included
    always @* begin
        periodLimit = 15'h0000;
        if (wakeupClockSelect) begin
            case (wakeupPeriodSelect)
                3'h1: periodLimit = `SWV_LIM_EXT1;
                3'h2: periodLimit = `SWV_LIM_EXT2;
                3'h3: periodLimit = `SWV_LIM_EXT3;
                3'h4: periodLimit = `SWV_LIM_EXT4;
                3'h5: periodLimit = `SWV_LIM_EXT5;
                3'h6: periodLimit = `SWV_LIM_EXT6;
                3'h7: periodLimit = `SWV_LIM_EXT7;
                default: periodLimit = 15'h0000;
            endcase
        end else begin
            case (wakeupPeriodSelect)
                3'h1: periodLimit = `SWV_LIM_INT1;
                3'h2: periodLimit = `SWV_LIM_INT2;
                3'h3: periodLimit = `SWV_LIM_INT3;
                3'h4: periodLimit = `SWV_LIM_INT4;
                3'h5: periodLimit = `SWV_LIM_INT5;
                3'h6: periodLimit = `SWV_LIM_INT6;
                3'h7: periodLimit = `SWV_LIM_INT7;
                default: periodLimit = 15'h0000;
            endcase
        end
    end

    // A new source or period restarts the count; a stale count above
    // a shorter limit would otherwise run on until it wraps
    assign wakeCfgChange = wakeWr &
        ({wdClockSelect, wdPeriod} !=
        {wakeupClockSelect, wakeupPeriodSelect});

    assign wakeExpire = (wakeupPeriodSelect != 3'h0) & timerStep &
        (periodCount == periodLimit);
    always @(posedge clk_sys) begin
        if (!rst_n || wakeupPeriodSelect == 3'h0) begin
            periodCount <= 15'h0000;
        end else if (wakeExpire || wakeCfgChange) begin
            periodCount <= 15'h0000;
        end else if (timerStep) begin
            periodCount <= periodCount + 15'h0001;
        end
    end

    // Wakeup control register and flag
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wakeupFlag <= 1'b0;
            wakeupClockSelect <= 1'b0;
            wakeupInterruptEnable <= 1'b0;
            wakeupPeriodSelect <= 3'h0;
        end else begin
            // set on expiry, set wins over acknowledge
            if (wakeExpire) begin
                wakeupFlag <= 1'b1;
            end else if (wakeAck) begin
                wakeupFlag <= 1'b0;
            end
            if (wakeWr) begin
                wakeupClockSelect <= wdClockSelect;
                wakeupInterruptEnable <= wdWakeIe;
                wakeupPeriodSelect <= wdPeriod;
            end
        end
    end

    // stop mode disables detection unless stop enable
    assign detectOn = supplyDropDetectEnable &
        (~stopMode | supplyDropStopEnable);

    // Supply-drop control register
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            supplyDropFlag <= 1'b0;
            supplyDropInterruptEnable <= 1'b0;
            supplyDropResetEnable <= 1'b0;
            supplyDropStopEnable <= 1'b0;
            supplyDropDetectEnable <= 1'b0;
            dropWritten <= 1'b0;
        end else begin
            // flag only while detecting; set wins
            if (detectOn & supplyDropEvent) begin
                supplyDropFlag <= 1'b1;
            end else if (dropAck) begin
                supplyDropFlag <= 1'b0;
            end
            if (dropWr) begin
                supplyDropInterruptEnable <= wdDropIe;
            end
            // stop enable stored once
            // Any write spends the once, so set all three together
            if (dropWr & ~dropWritten) begin
                dropWritten <= 1'b1;
                supplyDropResetEnable <= wdResetEnable;
                supplyDropStopEnable <= wdStopEnable;
                supplyDropDetectEnable <= wdDetectEnable;
            end
        end
    end

    // Request outputs, one cycle behind the flags
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wakeupIrq <= 1'b0;
        end else begin
            wakeupIrq <= wakeupFlag & wakeupInterruptEnable;
        end
    end

    // Supply-drop outputs are masked by detect enable as well as the flag,
    // so a flag left over after disable raises nothing
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            supplyDropIrq <= 1'b0;
            supplyDropReset <= 1'b0;
            detectActive <= 1'b0;
        end else begin
            supplyDropIrq <= supplyDropFlag & supplyDropInterruptEnable &
                supplyDropDetectEnable;
            // reset request while flagged
            // Level, so it holds until acknowledge or the reset clears it
            supplyDropReset <= supplyDropFlag & supplyDropResetEnable &
                supplyDropDetectEnable;
            detectActive <= detectOn;
        end
    end
endmodule // swv_wakeup_voltage

// >>> swv_regs.vh
// Purpose: Register map and field layout of the wakeup and supply-drop block
// Assumes: APB byte addresses, one 32-bit word per 8-bit register
// Notes: Offsets are not multiples of four, so they are register indices
`ifndef SWV_REGS_VH
`define SWV_REGS_VH
`define SWV_IDX_ID_HIGH 16'h1806
`define SWV_IDX_ID_LOW 16'h1807
`define SWV_IDX_WAKE_CTRL 16'h1808
`define SWV_IDX_DROP_CTRL 16'h1809
`define SWV_ADDR_W 18
`define SWV_BIT_FLAG 7
`define SWV_BIT_ACK 6
`define SWV_BIT_CLKSEL 5
`define SWV_BIT_WIE 4
`define SWV_BIT_DIE 5
`define SWV_BIT_DRE 4
`define SWV_BIT_DSE 3
`define SWV_BIT_DDE 2
`define SWV_PER_MSB 2
`define SWV_PER_LSB 0
`define SWV_LIM_INT1 15'h0007
`define SWV_LIM_INT2 15'h001f
`define SWV_LIM_INT3 15'h003f
`define SWV_LIM_INT4 15'h007f
`define SWV_LIM_INT5 15'h00ff
`define SWV_LIM_INT6 15'h01ff
`define SWV_LIM_INT7 15'h03ff
`define SWV_LIM_EXT1 15'h00ff
`define SWV_LIM_EXT2 15'h03ff
`define SWV_LIM_EXT3 15'h07ff
`define SWV_LIM_EXT4 15'h0fff
`define SWV_LIM_EXT5 15'h1fff
`define SWV_LIM_EXT6 15'h3fff
`define SWV_LIM_EXT7 15'h7fff
`define SWV_TICK_NS 1000000
`define SWV_CLK_NS 25
`endif

// >>> swv_checker_properties.sv
// Purpose: Port assertions for swv_wakeup_voltage
// Assumes: zero-wait APB, one byte per word
// Notes: Internal flags are seen only through reads and request lines
`timescale 1ns/1ps
`include "swv_regs.vh"
module swv_checker #(
    parameter [3:0] REVISION = 4'h1,
    parameter [11:0] PART_NUMBER = 12'h5a3
) (
    input wire clk_sys,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire supplyDropEvent,
    input wire wakeupIrq,
    input wire supplyDropIrq,
    input wire supplyDropReset
);
    localparam [31:0] AIDH = {`SWV_IDX_ID_HIGH, 2'b00};
    localparam [31:0] AIDL = {`SWV_IDX_ID_LOW, 2'b00};
    localparam [31:0] AWK = {`SWV_IDX_WAKE_CTRL, 2'b00};
    localparam [31:0] ADR = {`SWV_IDX_DROP_CTRL, 2'b00};
    wire known = paddr == AIDH || paddr == AIDL ||
        paddr == AWK || paddr == ADR;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_ack(a);
        psel && penable && pwrite && paddr == a && pstrb[0] && pwdata[6];
    endsequence
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one access cycle");
    a_err_unmapped: assert property (psel && !penable && !known |=> pslverr)
        else $error("unmapped access not refused");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read data not zero");
    a_rev_field: assert property (
        s_rd(AIDH) |=> prdata[7:4] == REVISION)
        else $error("revision field wrong");
    a_part_high: assert property (
        s_rd(AIDH) |=> prdata[3:0] == PART_NUMBER[11:8])
        else $error("high part number wrong");
    a_part_low: assert property (
        s_rd(AIDL) |=> prdata == PART_NUMBER[7:0])
        else $error("low part number wrong");
    a_wake_unused: assert property (
        s_rd(AWK) |=> !prdata[6] && !prdata[3])
        else $error("wakeup control reads bad bits");
    a_drop_ackrd: assert property (
        s_rd(ADR) |=> !prdata[6])
        else $error("drop acknowledge reads one");
    a_wake_ack: assert property (
        s_ack(AWK) |=> ##1 !wakeupIrq)
        else $error("wakeup request kept after acknowledge");
    a_drop_ack: assert property (
        !supplyDropEvent[*3] ##0 s_ack(ADR)
        |=> ##1 !supplyDropIrq && !supplyDropReset)
        else $error("drop request kept after acknowledge");
endmodule // swv_checker
bind swv_wakeup_voltage swv_checker #(.REVISION(REVISION),
    .PART_NUMBER(PART_NUMBER)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supplyDropEvent(supplyDropEvent),
    .wakeupIrq(wakeupIrq), .supplyDropIrq(supplyDropIrq),
    .supplyDropReset(supplyDropReset));

// >>> tb_top.sv
// Purpose: Self-checking bench for swv_wakeup_voltage
// Assumes: short tick parameter, zero-wait APB
// Notes: Period checks allow a window for tick phase
`timescale 1ns/1ps
`include "swv_regs.vh"
module tb_top;
    localparam integer TICK = 8;
    localparam [3:0] REV = 4'h9; // Arbitrary value
    localparam [11:0] PART = 12'h3c6; // Arbitrary value
    localparam [31:0] AIDH = {`SWV_IDX_ID_HIGH, 2'b00};
    localparam [31:0] AIDL = {`SWV_IDX_ID_LOW, 2'b00};
    localparam [31:0] AWK = {`SWV_IDX_WAKE_CTRL, 2'b00};
    localparam [31:0] ADR = {`SWV_IDX_DROP_CTRL, 2'b00};
    reg clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    reg extClk = 0, supplyDropEvent = 0, stopMode = 0, extRun = 0, rdErr;
    reg [31:0] paddr = 0, pwdata = 0, rd, r;
    reg [3:0] pstrb = 4'h1;
    reg [1:0] extDiv = 0;
    wire [31:0] prdata;
    wire pready, pslverr, wakeupIrq, supplyDropIrq, supplyDropReset, dAct;
    integer error_cnt = 0, check_count = 0, seed = 8, i, n, e, s;
    swv_wakeup_voltage #(.REVISION(REV), .PART_NUMBER(PART),
        .TICK_CYCLES(TICK)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extClk(extClk), .supplyDropEvent(supplyDropEvent),
        .stopMode(stopMode), .wakeupIrq(wakeupIrq),
        .supplyDropIrq(supplyDropIrq), .supplyDropReset(supplyDropReset),
        .detectActive(dAct));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // External clock rises every four system cycles
    always @(posedge clk_sys) begin
        extDiv <= extDiv + 2'd1;
        extClk <= extRun & extDiv[1];
    end
    function integer steps(input integer code, input integer ext);
        steps = (code == 1) ? (ext ? 256 : 8) : (1 << (code + (ext ? 8 : 3)));
    endfunction
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task fail_out;
        begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t wait ran out", $time);
            report_and_stop;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [31:0] a, input [31:0] d);
        integer k;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge clk_sys);
                k = k + 1;
            end while (pready !== 1'b1 && k < 16);
            if (k >= 16) fail_out;
            rd = prdata;
            rdErr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rst_seq;
        begin
            rst_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
            rst_n <= 1'b1;
            @(posedge clk_sys);
        end
    endtask
    task pause(input integer k);
        repeat (k) @(posedge clk_sys);
    endtask
    initial begin
        rst_seq;
        for (i = 0; i < 6; i = i + 1) begin
            r = $random(seed);
            apb(1, AIDH, r);
            apb(1, AIDL, r);
            // Period kept zero so no expiry can raise the flag here
            apb(1, AWK, (r & 32'hfffffff8) | 32'h40);
            apb(0, AIDH, 0);
            chk(rd, {24'h0, REV, PART[11:8]});
            apb(0, AIDL, 0);
            chk(rd, PART[7:0]);
            apb(0, AWK, 0);
            chk(rd, r & 32'h30);
        end
        // A write without byte lane 0 must leave the register alone
        pstrb <= 4'h2;
        apb(1, AWK, 32'h37);
        pstrb <= 4'h1;
        apb(0, AWK, 0);
        chk(rd, r & 32'h30);
        for (i = 1; i < 10; i = i + 1) begin
            e = i > 7;
            s = e ? i - 7 : i;
            extRun <= e;
            apb(1, AWK, 32'h40);
            apb(1, AWK, 32'h10 | (e << 5) | s);
            n = 0;
            while (wakeupIrq !== 1'b1 && n < 40000) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            if (n >= 40000) fail_out;
            n = n - steps(s, e) * (e ? 4 : TICK);
            chk(n > -12 && n < 12, 1);
            apb(0, AWK, 0);
            chk(rd, 32'h90 | (e << 5) | s);
        end
        apb(1, AWK, 32'h41);
        pause(100);
        chk(wakeupIrq, 0);
        apb(1, AWK, 32'h11);
        pause(2);
        chk(wakeupIrq, 1);
        // Stop the timer first so no expiry meets the acknowledge
        apb(1, AWK, 32'h10);
        apb(1, AWK, 32'h50);
        pause(300);
        chk(wakeupIrq, 0);
        apb(0, AWK, 0);
        chk(rd, 32'h10);
        apb(1, ADR, 32'h34);
        supplyDropEvent <= 1'b1;
        pause(3);
        supplyDropEvent <= 1'b0;
        pause(3);
        chk({supplyDropIrq, supplyDropReset, dAct}, 3'b111);
        apb(0, ADR, 0);
        chk(rd, 32'hb4);
        stopMode <= 1'b1;
        pause(3);
        chk(dAct, 0);
        stopMode <= 1'b0;
        apb(1, ADR, 32'h60);
        pause(2);
        chk(supplyDropIrq, 0);
        apb(0, ADR, 0);
        chk(rd, 32'h34);
        rst_seq;
        apb(1, ADR, 32'h0c);
        stopMode <= 1'b1;
        pause(3);
        chk(dAct, 1);
        stopMode <= 1'b0;
        apb(1, ADR, 32'h20);
        apb(0, ADR, 0);
        chk(rd, 32'h2c);
        rst_seq;
        apb(1, ADR, 32'h38);
        supplyDropEvent <= 1'b1;
        pause(3);
        supplyDropEvent <= 1'b0;
        pause(3);
        chk({supplyDropIrq, supplyDropReset, dAct}, 0);
        apb(0, ADR, 0);
        chk(rd, 32'h38);
        apb(0, ADR + 32'h4, 0);
        chk(rdErr, 1);
        chk(rd, 0);
        report_and_stop;
    end
endmodule // tb_top
